// [design/input_map_regs.vh]
/*
 * Register offsets, field positions, reset values, mode codes and timing
 * figures for the input mapping and idle control block.
 * Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
 */
`ifndef INPUT_MAP_REGS_VH
`define INPUT_MAP_REGS_VH

// Byte offsets of the register words
`define OFS_OUT_SWITCH 8'h00
`define OFS_MAP_ZERO 8'h04
`define OFS_MAP_ONE 8'h08
`define OFS_INPUT_LEVEL 8'h0c
`define OFS_STATUS 8'h10

// Reset values: input zero drives channel 2, input one drives channel 3
`define OUT_SWITCH_RST 8'h00
`define MAP_ZERO_RST 8'h04
`define MAP_ONE_RST 8'h08

// Status word field positions
`define ST_MODE_LSB 0
`define ST_SERIAL_OK_BIT 2
`define ST_UV_EN_BIT 3
`define ST_CHAN_LSB 8

// Operating mode codes
`define MODE_SLEEP 2'h0
`define MODE_IDLE 2'h1
`define MODE_ACTIVE 2'h2
`define MODE_FALLBACK 2'h3

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Clock period and mode wake latency
`define CLK_PERIOD_PS 8000
`define MODE_WAKE_NS 100

`endif

// [design/sync_chain.v]
/*
 * Two-stage synchroniser for a group of level inputs.
 * Assumes inputs are quasi-static levels; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module sync_chain #(
    parameter W = 1
) (
    core_clk,
    rst_b,
    din,
    dout
);
    input wire core_clk;
    input wire rst_b;
    input wire [W-1:0] din;
    output reg [W-1:0] dout;

    // First stage, read by the second stage only
    reg [W-1:0] meta_r;

    // Two flops in a row to settle metastability
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// [design/reset_release.v]
/*
 * Reset generator for the register bank: asserts at once on any low source,
 * releases two clock edges after all sources are high.
 * Assumes core_clk runs while the sources are released.
 */
`timescale 1ns/1ps
module reset_release (
    core_clk,
    arst_b,
    rst_out_b
);
    input wire core_clk;
    input wire arst_b;
    output reg rst_out_b;

    // Release shift stage
    reg stage_r;

    // Assert asynchronously, release on the clock to avoid recovery hazards
    always @(posedge core_clk or negedge arst_b) begin
        if (!arst_b) begin
            stage_r <= 1'b0;
            rst_out_b <= 1'b0;
        end else begin
            stage_r <= 1'b1;
            rst_out_b <= stage_r;
        end
    end
endmodule

// [design/input_map_and_idle_control.v]
/*
 * Control logic of an eight-channel low-side switch: input pin mapping,
 * OR with the output switch register, input level monitor, idle pin modes
 * and supply undervoltage gating, with registers on an AXI4-Lite slave.
 * Assumes pins are synchronous levels and the host keeps idle levels stable.
 */
// How it works
// - Reset maps input zero->ch2, input one->ch3
// - Per-input map registers add or replace channels
// - Channel request ORs switch bit and mapped inputs
// - Input level monitor reads current pin levels
// - Monitor stays valid in fallback mode
// - Idle low, input high: fallback, default channels
// - Idle low, inputs low: sleep mode
// - Idle low resets all registers to default
// - Sleep disables both undervoltage detectors
// - Sleep refuses serial access, output disabled
// - Both supplies low: stages, access, registers blocked
// - Digital supply low: access blocked, registers reset
// - Switch-on request wakes to active or fallback
// - Analog undervoltage: on channels hold, no new
`timescale 1ns/1ps
`include "input_map_regs.vh"
module input_map_and_idle_control #(
    parameter NCH = 8,
    parameter WAKE_NS = `MODE_WAKE_NS
) (
    core_clk,
    rst_b,
    parallel_input_pins,
    idle_pin,
    vs_uv,
    vdd_uv,
    channel_on_r,
    mode_r,
    uv_detect_en_r,
    serial_out_en_r,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input wire core_clk;
    input wire rst_b;
    input wire [1:0] parallel_input_pins; // Bit 0 input zero, bit 1 input one
    input wire idle_pin; // Low requests sleep or fallback
    input wire vs_uv; // Analog supply below threshold
    input wire vdd_uv; // Digital supply below threshold
    output reg [NCH-1:0] channel_on_r; // Power stage on requests
    output reg [1:0] mode_r; // Current operating mode
    output reg uv_detect_en_r; // Undervoltage detectors enabled
    output reg serial_out_en_r; // Serial output may be driven
    input wire [7:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output reg s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output reg s_axi_wready;
    output reg [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [7:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output reg s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;

    // Wake latency rounded up to whole cycles, at least one
    localparam WAKE_RAW = (WAKE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    localparam WAKE_CYC = (WAKE_RAW < 1) ? 1 : WAKE_RAW;
    localparam [31:0] WAKE_LAST_W = WAKE_CYC - 1;
    localparam [7:0] WAKE_LAST = WAKE_LAST_W[7:0];
    localparam [1:0] ST_SLEEP = `MODE_SLEEP;
    localparam [1:0] ST_IDLE = `MODE_IDLE;
    localparam [1:0] ST_ACTIVE = `MODE_ACTIVE;
    localparam [1:0] ST_FALLBACK = `MODE_FALLBACK;
    wire [1:0] in_s; // Synchronised input pins
    wire idle_s; // Synchronised idle pin
    wire bank_rst_b; // Register bank reset
    reg [7:0] out_switch_r; // Software switch bits
    reg [7:0] map_zero_r; // Channels driven by input zero
    reg [7:0] map_one_r; // Channels driven by input one
    reg [7:0] wake_cnt_r; // Mode transition latency counter
    reg [1:0] mode_nxt;
    reg [7:0] wake_cnt_nxt;
    reg [NCH-1:0] chan_req; // Channel request before supply gating
    reg [NCH-1:0] channel_on_nxt;
    reg [31:0] rd_word; // Read data mux
    reg rd_err; // Read address unmapped or blocked
    reg [7:0] aw_addr_r; // Captured write address
    reg [31:0] w_data_r; // Captured write data
    reg [3:0] w_strb_r; // Captured byte enables
    reg aw_got_r; // Write address held
    reg w_got_r; // Write data held

    sync_chain #(.W(3)) u_pin_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .din({idle_pin, parallel_input_pins}),
        .dout({idle_s, in_s})
    );
    wire any_in = |in_s;
    // Sleep condition: idle low with both inputs low
    wire sleep_cond = !idle_s && !any_in;
    // Undervoltage flags count only while the detectors run
    wire vdd_uv_m = vdd_uv && uv_detect_en_r;
    wire vs_uv_m = vs_uv && uv_detect_en_r;
    wire both_uv_m = vdd_uv_m && vs_uv_m;
    wire serial_block = sleep_cond || vdd_uv_m || both_uv_m;
    reset_release u_bank_rst (
        .core_clk(core_clk),
        .arst_b(rst_b && !vdd_uv_m && !both_uv_m),
        .rst_out_b(bank_rst_b)
    );
    // OR of switch and mapped inputs
    wire [7:0] active_req = out_switch_r | ({8{in_s[0]}} & map_zero_r) | ({8{in_s[1]}} & map_one_r);
    wire [7:0] fallback_req = ({8{in_s[0]}} & `MAP_ZERO_RST) | ({8{in_s[1]}} & `MAP_ONE_RST);
    wire want_on = |active_req;

    // Mode selection; only entries from sleep or idle wait for wake latency
    always @* begin
        mode_nxt = mode_r;
        wake_cnt_nxt = 8'h00;
        if (!idle_s) begin
            if (any_in) begin
                if (mode_r == ST_SLEEP || mode_r == ST_IDLE) begin
                    if (wake_cnt_r == WAKE_LAST) begin
                        mode_nxt = ST_FALLBACK;
                    end else begin
                        wake_cnt_nxt = wake_cnt_r + 8'h01;
                    end
                end else begin
                    mode_nxt = ST_FALLBACK;
                end
            end else begin
                mode_nxt = ST_SLEEP;
            end
        end else begin
            case (mode_r)
                // Active holds while idle stays high
                ST_ACTIVE: mode_nxt = ST_ACTIVE;
                ST_SLEEP, ST_IDLE: begin
                    if (want_on) begin
                        if (wake_cnt_r == WAKE_LAST) begin
                            mode_nxt = ST_ACTIVE;
                        end else begin
                            wake_cnt_nxt = wake_cnt_r + 8'h01;
                        end
                    end else begin
                        mode_nxt = ST_IDLE;
                    end
                end
                // Idle released: back to normal control
                ST_FALLBACK: mode_nxt = want_on ? ST_ACTIVE : ST_IDLE;
                default: mode_nxt = ST_SLEEP;
            endcase
        end
    end

    // Channel requests per mode and supply gating of the power stages
    always @* begin
        case (mode_r)
            ST_ACTIVE: chan_req = active_req[NCH-1:0];
            ST_FALLBACK: chan_req = fallback_req[NCH-1:0];
            default: chan_req = {NCH{1'b0}};
        endcase
        if (both_uv_m) begin
            channel_on_nxt = {NCH{1'b0}};
        end else if (vs_uv_m) begin
            channel_on_nxt = chan_req & channel_on_r;
        end else begin
            channel_on_nxt = chan_req;
        end
    end

    // Mode, channel and supervision flops; outputs come from here
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= ST_SLEEP;
            wake_cnt_r <= 8'h00;
            channel_on_r <= {NCH{1'b0}};
            uv_detect_en_r <= 1'b0;
            serial_out_en_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            channel_on_r <= channel_on_nxt;
            uv_detect_en_r <= !sleep_cond;
            serial_out_en_r <= !serial_block;
        end
    end

    // Write path accepts address and data in either order
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
    wire wr_hit = (aw_addr_r == `OFS_OUT_SWITCH) || (aw_addr_r == `OFS_MAP_ZERO) || (aw_addr_r == `OFS_MAP_ONE);
    wire wr_ok = wr_go && wr_hit && !serial_block && w_strb_r[0];

    // AXI write handshake state
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                // Unmapped or blocked writes still answer, with an error code
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_hit && !serial_block) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register bank; idle low or digital undervoltage returns it to defaults
    always @(posedge core_clk or negedge bank_rst_b) begin
        if (!bank_rst_b) begin
            out_switch_r <= `OUT_SWITCH_RST;
            map_zero_r <= `MAP_ZERO_RST;
            map_one_r <= `MAP_ONE_RST;
        end else if (!idle_s) begin
            out_switch_r <= `OUT_SWITCH_RST;
            map_zero_r <= `MAP_ZERO_RST;
            map_one_r <= `MAP_ONE_RST;
        end else if (wr_ok) begin
            case (aw_addr_r)
                `OFS_OUT_SWITCH: out_switch_r <= w_data_r[7:0];
                `OFS_MAP_ZERO: map_zero_r <= w_data_r[7:0];
                `OFS_MAP_ONE: map_one_r <= w_data_r[7:0];
                default: out_switch_r <= out_switch_r;
            endcase
        end
    end

    // Read decode; byte lane 0 holds data, status also has channels in lane 1; other bits read zero
    always @* begin
        rd_word = 32'h00000000;
        rd_err = 1'b0;
        case ({s_axi_araddr[7:2], 2'b00})
            `OFS_OUT_SWITCH: rd_word[7:0] = out_switch_r;
            `OFS_MAP_ZERO: rd_word[7:0] = map_zero_r;
            `OFS_MAP_ONE: rd_word[7:0] = map_one_r;
            `OFS_INPUT_LEVEL: rd_word[1:0] = in_s;
            `OFS_STATUS: begin
                rd_word[`ST_MODE_LSB+1:`ST_MODE_LSB] = mode_r;
                rd_word[`ST_SERIAL_OK_BIT] = serial_out_en_r;
                rd_word[`ST_UV_EN_BIT] = uv_detect_en_r;
                rd_word[`ST_CHAN_LSB+NCH-1:`ST_CHAN_LSB] = channel_on_r;
            end
            default: rd_err = 1'b1;
        endcase
        if (serial_block) begin
            rd_word = 32'h00000000;
            rd_err = 1'b1;
        end
    end

    // AXI read handshake: data one cycle after address is taken
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// [bench/input_map_chk.sv]
/* Checker for the input mapping and idle control block.
   Assumes it is bound to the top module and watches its ports only. */
`timescale 1ns/1ps
`include "input_map_regs.vh"
module input_map_chk #(
    parameter NCH = 8,
    parameter WAKE_NS = 100
) (
    input wire core_clk,
    input wire rst_b,
    input wire [1:0] parallel_input_pins,
    input wire idle_pin,
    input wire vs_uv,
    input wire vdd_uv,
    input wire [NCH-1:0] channel_on_r,
    input wire [1:0] mode_r,
    input wire uv_detect_en_r,
    input wire serial_out_en_r,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Sync, mode step, wake and channel step before fallback settles
    localparam int FB_LAT = 6 + (WAKE_NS + 7) / 8;
    reg [7:0] fb_cnt_r; // Cycles of steady fallback request
    reg [7:0] fb_cnt_nxt;
    // Count stays at zero whenever a supply is low, so gating never trips it
    always @* begin
        fb_cnt_nxt = fb_cnt_r;
        if (idle_pin || parallel_input_pins != 2'b01 || vs_uv || vdd_uv) fb_cnt_nxt = 8'h00;
        else if (fb_cnt_r != 8'hff) fb_cnt_nxt = fb_cnt_r + 8'h01;
    end
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) fb_cnt_r <= 8'h00;
        else fb_cnt_r <= fb_cnt_nxt;
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_sleep_held;
        (!idle_pin && parallel_input_pins == 2'b00) [*5];
    endsequence
    a_write_answer: assert property (s_wr_taken |=> !s_axi_awready ##[0:1] s_axi_bvalid)
        else $error("write answer late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_sleep_quiet: assert property (s_sleep_held |-> mode_r == `MODE_SLEEP && !uv_detect_en_r)
        else $error("sleep not entered");
    a_sleep_no_out: assert property (s_sleep_held |-> !serial_out_en_r && channel_on_r == 0)
        else $error("serial output live in sleep");
    a_fallback_default: assert property (fb_cnt_r >= FB_LAT |-> mode_r == `MODE_FALLBACK && channel_on_r == 'h4)
        else $error("fallback channels wrong");
    a_both_uv_off: assert property ((vs_uv && vdd_uv) [*3] |-> channel_on_r == 0)
        else $error("stage on in double undervoltage");
    a_blocked_write: assert property ($rose(s_axi_bvalid) && !serial_out_en_r && !$past(serial_out_en_r)
        |-> s_axi_bresp == `RESP_SLVERR)
        else $error("blocked write accepted");
    a_blocked_read: assert property ($rose(s_axi_rvalid) && !serial_out_en_r && !$past(serial_out_en_r)
        |-> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 0)
        else $error("blocked read answered");
endmodule
bind input_map_and_idle_control input_map_chk #(.NCH(NCH), .WAKE_NS(WAKE_NS)) chk (
    .core_clk(core_clk), .rst_b(rst_b), .parallel_input_pins(parallel_input_pins), .idle_pin(idle_pin),
    .vs_uv(vs_uv), .vdd_uv(vdd_uv), .channel_on_r(channel_on_r), .mode_r(mode_r),
    .uv_detect_en_r(uv_detect_en_r), .serial_out_en_r(serial_out_en_r), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [bench/host_pins.sv]
/* Host model for the control pins: applies requested pin levels.
   Assumes the bench posts requests; each level is kept a minimum time. */
`timescale 1ns/1ps
module host_pins #(
    parameter MIN_HOLD = 4
) (
    input wire core_clk,
    input wire req_idle,
    input wire [1:0] req_pins,
    output reg idle_pin = 1'b1,
    output reg [1:0] parallel_input_pins = 2'b00
);
    reg [7:0] held_r = 8'h00; // Cycles the present levels have stood
    // minimum level hold
    // A new level waits until the old one has stood long enough
    always @(posedge core_clk) begin
        if (held_r < MIN_HOLD) held_r <= held_r + 8'h01;
        else if (req_idle !== idle_pin || req_pins !== parallel_input_pins) begin
            idle_pin <= req_idle;
            parallel_input_pins <= req_pins;
            held_r <= 8'h00;
        end
    end
endmodule

// [bench/input_map_and_idle_control_tb_top.sv]
/* Testbench for the input mapping and idle control block.
   Assumes the checker is bound in and a one-cycle wake latency. */
`timescale 1ns/1ps
`include "input_map_regs.vh"
module input_map_and_idle_control_tb_top;
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg req_idle = 1'b1; // Levels asked of the host model
    reg [1:0] req_pins = 2'b00;
    reg vs_uv = 1'b0;
    reg vdd_uv = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg [3:0] wstrb = 4'hf;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire idle_pin, awready, wready, bvalid, arready, rvalid, uv_en, so_en;
    wire [1:0] in_pins, mode, bresp, rresp;
    wire [7:0] ch;
    wire [31:0] rdata;
    integer n_errors = 0, n_tests = 0;
    initial forever #4 core_clk = ~core_clk;
    host_pins pins (.core_clk(core_clk), .req_idle(req_idle), .req_pins(req_pins), .idle_pin(idle_pin),
        .parallel_input_pins(in_pins));
    input_map_and_idle_control #(.WAKE_NS(8)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .parallel_input_pins(in_pins), .idle_pin(idle_pin), .vs_uv(vs_uv), .vdd_uv(vdd_uv),
        .channel_on_r(ch), .mode_r(mode), .uv_detect_en_r(uv_en), .serial_out_en_r(so_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge core_clk);
    endtask
    // Write one word; ready is raised late so the response must stand
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        integer k;
        begin
            @(posedge core_clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            k = 0;
            while (k < 60) begin
                @(posedge core_clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid && bready) k = 99;
                else begin
                    k = k + 1;
                    bready <= bvalid;
                end
            end
            bready <= 1'b0;
            if (k != 99) begin
                n_errors = n_errors + 1;
                $display("ERROR at %0t: write answer missing", $time);
            end
            chk(bresp, er);
        end
    endtask
    // Read one word and judge data and response together
    task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        integer k;
        begin
            @(posedge core_clk);
            araddr <= a;
            arvalid <= 1'b1;
            k = 0;
            while (k < 60) begin
                @(posedge core_clk);
                if (arready) arvalid <= 1'b0;
                if (rvalid && rready) k = 99;
                else begin
                    k = k + 1;
                    rready <= rvalid;
                end
            end
            rready <= 1'b0;
            if (k != 99) begin
                n_errors = n_errors + 1;
                $display("ERROR at %0t: read answer missing", $time);
            end
            chk(rdata, ed);
            chk(rresp, er);
        end
    endtask
    task t_defaults;
        begin
            rd(`OFS_MAP_ZERO, 32'h4, `RESP_OKAY); // input zero default
            rd(`OFS_MAP_ONE, 32'h8, `RESP_OKAY); // input one default
            rd(`OFS_OUT_SWITCH, 32'h0, `RESP_OKAY);
        end
    endtask
    // Replace one map, extend the other, OR with the switch word
    task t_map;
        begin
            wr(`OFS_MAP_ZERO, 32'h11, `RESP_OKAY);
            req_pins <= 2'b01;
            wt(16);
            chk(ch, 8'h11); // replaced channels
            chk(mode, `MODE_ACTIVE); // woke on request
            wr(`OFS_MAP_ONE, 32'h09, `RESP_OKAY);
            wr(`OFS_OUT_SWITCH, 32'h80, `RESP_OKAY);
            req_pins <= 2'b11;
            wt(16);
            chk(ch, 8'h99); // switch word ORed in
            rd(`OFS_INPUT_LEVEL, 32'h3, `RESP_OKAY); // pin levels
            rd(`OFS_STATUS, 32'h0000990e, `RESP_OKAY); // status shows channels and mode
            wstrb <= 4'he;
            wr(`OFS_OUT_SWITCH, 32'h00, `RESP_OKAY);
            wstrb <= 4'hf;
            rd(`OFS_OUT_SWITCH, 32'h80, `RESP_OKAY); // lane zero off keeps switch word
            chk(so_en, 1'b1); // access open while active
            wr(`OFS_INPUT_LEVEL, 32'h0, `RESP_SLVERR);
            wr(8'h14, 32'h1, `RESP_SLVERR);
        end
    endtask
    // Idle low with input zero high, then all inputs low
    task t_idle;
        begin
            req_pins <= 2'b01;
            req_idle <= 1'b0;
            wt(20);
            chk(ch, 8'h04); // default channel only
            chk(mode, `MODE_FALLBACK); // fallback mode entered
            rd(`OFS_INPUT_LEVEL, 32'h1, `RESP_OKAY); // monitor live
            rd(`OFS_MAP_ZERO, 32'h4, `RESP_OKAY); // map back to default
            wr(`OFS_OUT_SWITCH, 32'hff, `RESP_OKAY);
            wt(4);
            chk(ch, 8'h04); // write has no effect
            req_pins <= 2'b00;
            wt(16);
            chk(uv_en, 1'b0); // detectors off
            chk(mode, `MODE_SLEEP); // sleep mode entered
            chk(so_en, 1'b0); // serial output disabled
            wr(`OFS_OUT_SWITCH, 32'h1, `RESP_SLVERR); // write refused
            rd(`OFS_MAP_ONE, 32'h0, `RESP_SLVERR); // read refused
        end
    endtask
    // Supply undervoltage cases
    task t_uv;
        begin
            req_idle <= 1'b1;
            wt(16);
            wr(`OFS_OUT_SWITCH, 32'h01, `RESP_OKAY);
            wt(4);
            chk(ch, 8'h01); // switch bit alone
            vs_uv <= 1'b1;
            wr(`OFS_OUT_SWITCH, 32'h03, `RESP_OKAY);
            wt(16);
            chk(ch, 8'h01); // on stays, new stays off
            vdd_uv <= 1'b1;
            wt(4);
            chk(ch, 8'h00); // stages blocked
            wr(`OFS_OUT_SWITCH, 32'h1, `RESP_SLVERR); // access blocked
            vs_uv <= 1'b0;
            wt(2);
            rd(`OFS_OUT_SWITCH, 32'h0, `RESP_SLVERR); // access blocked
            vdd_uv <= 1'b0;
            wt(8);
            rd(`OFS_OUT_SWITCH, 32'h0, `RESP_OKAY); // registers reset
        end
    endtask
    task results;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        wt(4);
        rst_b <= 1'b1;
        wt(10);
        t_defaults;
        t_map;
        t_idle;
        t_uv;
        results;
    end
    // Whole run takes under a thousand cycles
    initial begin
        wt(20000);
        n_errors = n_errors + 1;
        results;
    end
endmodule
